// ---- rtl/upi_phy_pins.sv ----
// Link-pin logic of the transceiver: strap decode, clock start-up and the
// eight-bit link handshake. Assumes a 10 MHz system clock and a PLL clock
// at the interface rate on i_link_clock; core-side byte ports run on i_link_clock, o_running and o_ref_freq_khz on i_clock.
//
// Contract
// - Launch link outputs on interface clock rising edge
// - Straps pick 13, 19.2, 26 or 24 MHz
// - Data bus eight bits, bit 7 MSB
// - NXT high in cycle byte is accepted
// - With data to send, DIR high, own bus
// - Idle: DIR low, release bus, watch commands
// - STP: last byte was previous cycle, complete
// - Reset low: suspended, all outputs tri-stated
`timescale 1ns/1ps
module upi_phy_pins #(
  parameter int unsigned START_13_CYCLES = upi_pkg::START_13_CYC,
  parameter int unsigned START_19P2_CYCLES = upi_pkg::START_19P2_CYC,
  parameter int unsigned START_26_CYCLES = upi_pkg::START_26_CYC,
  parameter int unsigned START_24_CYCLES = upi_pkg::START_24_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_link_clock,
  input wire logic [1:0] i_reference_select_straps,
  input wire logic [upi_pkg::DATA_MSB:upi_pkg::DATA_LSB] i_data_in,
  input wire logic i_stp,
  input upi_pkg::upi_byte_t i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_tx_ready,
  output logic o_interface_clock_out,
  output logic o_clock_oe_b,
  output upi_pkg::upi_pins_t o_pins,
  output logic o_rx_ready,
  output upi_pkg::upi_byte_t o_tx_byte,
  output logic o_tx_valid,
  output logic [15:0] o_ref_freq_khz,
  output logic o_running
);
  import upi_pkg::*;

  // Start-up sequencer on the system clock
  logic [1:0] straps_s;
  upi_start_state_t ss_r;
  upi_start_state_t ss_nxt;
  logic [1:0] straps_r;
  logic [1:0] straps_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] freq_r;
  logic [15:0] freq_nxt;
  logic running_r;
  logic running_nxt;
  logic clock_oe_b_r;
  logic clock_oe_b_nxt;

  upi_sync #(.WIDTH(2)) u_strap_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_level(i_reference_select_straps),
    .o_level(straps_s)
  );

  always_comb
  begin
    ss_nxt = ss_r;
    straps_nxt = straps_r;
    settle_nxt = settle_r;
    cnt_nxt = cnt_r;
    freq_nxt = freq_r;
    running_nxt = running_r;
    clock_oe_b_nxt = clock_oe_b_r;
    case (ss_r)
      SS_SETTLE:
      begin
        settle_nxt = settle_r + 2'h1;
        if (settle_r == SETTLE_CYC)
        begin
          ss_nxt = SS_LOAD;
        end
      end
      SS_LOAD:
      begin
        // Straps are caught once, after reset release
        straps_nxt = straps_s;
        freq_nxt = strap_freq(straps_s);
        case (straps_s)
          REFSEL_13: cnt_nxt = START_13_CYCLES[15:0];
          REFSEL_19P2: cnt_nxt = START_19P2_CYCLES[15:0];
          REFSEL_26: cnt_nxt = START_26_CYCLES[15:0];
          REFSEL_24: cnt_nxt = START_24_CYCLES[15:0];
          default: cnt_nxt = START_13_CYCLES[15:0];
        endcase
        ss_nxt = SS_WAIT;
      end
      SS_WAIT:
      begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r <= CNT_LAST)
        begin
          // Interface clock starts once the PLL has had its time
          ss_nxt = SS_RUN;
          cnt_nxt = CNT_RESET;
          running_nxt = 1'b1;
          clock_oe_b_nxt = 1'b0;
        end
      end
      SS_RUN:
      begin
        running_nxt = 1'b1;
        clock_oe_b_nxt = 1'b0;
      end
      default:
      begin
        ss_nxt = SS_SETTLE;
      end
    endcase
  end

  // Reset holds the clock pin released
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ss_r <= SS_SETTLE;
      straps_r <= REFSEL_13;
      settle_r <= 2'h0;
      cnt_r <= CNT_RESET;
      freq_r <= FREQ_RESET;
      running_r <= 1'b0;
      clock_oe_b_r <= 1'b1;
    end
    else
    begin
      ss_r <= ss_nxt;
      straps_r <= straps_nxt;
      settle_r <= settle_nxt;
      cnt_r <= cnt_nxt;
      freq_r <= freq_nxt;
      running_r <= running_nxt;
      clock_oe_b_r <= clock_oe_b_nxt;
    end
  end

  assign o_ref_freq_khz = freq_r;
  assign o_running = running_r;
  assign o_clock_oe_b = clock_oe_b_r;
  // PLL clock forwarded; its pad enable stays off until start-up is done
  assign o_interface_clock_out = i_link_clock;

  // Link-side sequencer on the interface clock
  logic run_l;
  upi_link_state_t ls_r;
  upi_link_state_t ls_nxt;
  upi_pins_t pins_r;
  upi_pins_t pins_nxt;
  logic rx_ready_r;
  logic rx_ready_nxt;
  upi_byte_t pend_r;
  upi_byte_t pend_nxt;
  logic pend_valid_r;
  logic pend_valid_nxt;
  upi_byte_t txb_r;
  upi_byte_t txb_nxt;
  logic tx_valid_r;
  logic tx_valid_nxt;
  logic take_link;
  logic take_phy;

  upi_sync #(.WIDTH(1)) u_run_sync (
    .i_clock(i_link_clock),
    .i_rst_b(i_rst_b),
    .i_level(running_r),
    .o_level(run_l)
  );

  // A link byte counts at the edge that ends its NXT cycle, unless STP stands
  assign take_link = (ls_r == LS_LINK_RECV) && pins_r.nxt && !i_stp;
  assign take_phy = (ls_r == LS_PHY_SEND) && rx_ready_r && i_rx_valid;

  always_comb
  begin
    ls_nxt = ls_r;
    pins_nxt = pins_r;
    pins_nxt.nxt = 1'b0;
    pins_nxt.dir_oe_b = !run_l;
    pins_nxt.nxt_oe_b = !run_l;
    rx_ready_nxt = 1'b0;
    pend_nxt = pend_r;
    pend_valid_nxt = pend_valid_r;
    txb_nxt = txb_r;
    tx_valid_nxt = 1'b0;
    case (ls_r)
      LS_IDLE:
      begin
        pins_nxt.dir = 1'b0;
        pins_nxt.data_oe_b = 1'b1;
        pins_nxt.data = DATA_IDLE;
        if (run_l && (i_data_in != DATA_IDLE))
        begin
          // Link command seen on the bus; it wins over our own data
          ls_nxt = LS_LINK_RECV;
          pins_nxt.nxt = i_tx_ready;
        end
        else if (run_l && i_rx_valid)
        begin
          ls_nxt = LS_TURN_PHY;
          pins_nxt.dir = 1'b1;
        end
      end
      LS_LINK_RECV:
      begin
        if (take_link)
        begin
          // Hold the byte until the next one or STP shows whether it is last
          if (pend_valid_r)
          begin
            txb_nxt = '{last: 1'b0, data: pend_r.data};
            tx_valid_nxt = 1'b1;
          end
          pend_nxt = '{last: 1'b0, data: i_data_in};
          pend_valid_nxt = 1'b1;
        end
        if (i_stp)
        begin
          // Byte of the previous cycle closes the transfer
          if (pend_valid_r)
          begin
            txb_nxt = '{last: 1'b1, data: pend_r.data};
            tx_valid_nxt = 1'b1;
          end
          pend_valid_nxt = 1'b0;
          ls_nxt = LS_IDLE;
        end
        else
        begin
          pins_nxt.nxt = i_tx_ready;
        end
      end
      LS_TURN_PHY:
      begin
        // Turnaround: bus not driven, nothing sampled
        pins_nxt.data_oe_b = 1'b0;
        ls_nxt = LS_PHY_SEND;
        rx_ready_nxt = 1'b1;
      end
      LS_PHY_SEND:
      begin
        pins_nxt.data_oe_b = 1'b0;
        if (take_phy)
        begin
          pins_nxt.data = i_rx_byte.data;
          pins_nxt.nxt = 1'b1;
          if (i_rx_byte.last)
          begin
            ls_nxt = LS_PHY_DONE;
          end
          else
          begin
            rx_ready_nxt = 1'b1;
          end
        end
        else
        begin
          pins_nxt.data = DATA_IDLE;
          rx_ready_nxt = 1'b1;
        end
      end
      LS_PHY_DONE:
      begin
        // Give the bus back to the link
        pins_nxt.dir = 1'b0;
        pins_nxt.data_oe_b = 1'b1;
        pins_nxt.data = DATA_IDLE;
        ls_nxt = LS_TURN_LINK;
      end
      LS_TURN_LINK:
      begin
        // Turnaround after DIR falls: the bus is ignored
        ls_nxt = LS_IDLE;
      end
      default:
      begin
        ls_nxt = LS_IDLE;
        pins_nxt = PINS_RESET;
      end
    endcase
  end

  // All link outputs launch on the rising edge and float under reset
  always_ff @(posedge i_link_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ls_r <= LS_IDLE;
      pins_r <= PINS_RESET;
      rx_ready_r <= 1'b0;
      pend_r <= BYTE_RESET;
      pend_valid_r <= 1'b0;
      txb_r <= BYTE_RESET;
      tx_valid_r <= 1'b0;
    end
    else
    begin
      ls_r <= ls_nxt;
      pins_r <= pins_nxt;
      rx_ready_r <= rx_ready_nxt;
      pend_r <= pend_nxt;
      pend_valid_r <= pend_valid_nxt;
      txb_r <= txb_nxt;
      tx_valid_r <= tx_valid_nxt;
    end
  end

  assign o_pins = pins_r;
  assign o_rx_ready = rx_ready_r;
  assign o_tx_byte = txb_r;
  assign o_tx_valid = tx_valid_r;

  // Checks on the interface clock
  sequence s_grab;
    (ls_r == LS_IDLE) && run_l && (i_data_in == DATA_IDLE) && i_rx_valid;
  endsequence

  sequence s_own_after_turn;
    (o_pins.dir && o_pins.data_oe_b) ##1 (o_pins.dir && !o_pins.data_oe_b);
  endsequence

  sequence s_last_taken;
    take_phy && i_rx_byte.last;
  endsequence

  sequence s_release;
    o_pins.dir ##1 (!o_pins.dir && o_pins.data_oe_b) ##1 (ls_r == LS_IDLE);
  endsequence

  property p_grab_bus;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    s_grab |=> s_own_after_turn;
  endproperty
  a_grab_bus: assert property (p_grab_bus) else $error("DIR rise not followed by turnaround then drive");

  property p_release_bus;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    s_last_taken |=> s_release;
  endproperty
  a_release_bus: assert property (p_release_bus) else $error("Bus not handed back after last byte");

  property p_idle_released;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    !o_pins.dir |-> o_pins.data_oe_b;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("Data driven while DIR low");

  property p_turn_phy;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    $rose(o_pins.dir) |-> o_pins.data_oe_b && !o_pins.nxt;
  endproperty
  a_turn_phy: assert property (p_turn_phy) else $error("Data driven in turnaround cycle");

  property p_capture;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    take_link |=> pend_valid_r && (pend_r.data == $past(i_data_in));
  endproperty
  a_capture: assert property (p_capture) else $error("Accepted byte not captured");

  property p_nxt_paced;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    (o_pins.nxt && !o_pins.dir) |-> $past(i_tx_ready);
  endproperty
  a_nxt_paced: assert property (p_nxt_paced) else $error("NXT raised without core ready");

  property p_stp_last;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    ((ls_r == LS_LINK_RECV) && i_stp && pend_valid_r) |=> o_tx_valid && o_tx_byte.last && !o_pins.nxt;
  endproperty
  a_stp_last: assert property (p_stp_last) else $error("STP did not close the transfer");

  property p_float_stopped;
    @(posedge i_link_clock) disable iff (!i_rst_b)
    !run_l |=> o_pins.dir_oe_b && o_pins.nxt_oe_b && o_pins.data_oe_b;
  endproperty
  a_float_stopped: assert property (p_float_stopped) else $error("Pins driven before clock runs");

  // Checks on the system clock
  property p_freq;
    @(posedge i_clock) disable iff (!i_rst_b)
    (ss_r == SS_RUN) |-> (o_ref_freq_khz == strap_freq(straps_s));
  endproperty
  a_freq: assert property (p_freq) else $error("Reference frequency does not match straps");

  property p_start;
    @(posedge i_clock) disable iff (!i_rst_b)
    $rose(o_running) |-> ($past(cnt_r) == CNT_LAST) && !o_clock_oe_b;
  endproperty
  a_start: assert property (p_start) else $error("Clock started before wait ended");

  property p_settle_off;
    @(posedge i_clock) disable iff (!i_rst_b)
    (ss_r == SS_SETTLE) |-> o_clock_oe_b && !o_running;
  endproperty
  a_settle_off: assert property (p_settle_off) else $error("Clock pin enabled during start-up");

endmodule

// ---- rtl/upi_pkg.sv ----
// Constants, types and helpers for the transceiver link-pin logic.
// Assumes a 10 MHz system clock and a separate interface clock from the PLL.
package upi_pkg;

  // System clock
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_MHZ = CLOCK_HZ / 1_000_000;

  // Interface clock rate launched at the link
  localparam int IFC_CLOCK_MHZ = 60;

  // Link data bus
  localparam int DATA_W = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam logic [DATA_MSB:DATA_LSB] DATA_IDLE = 8'h00;

  // Reference-select strap codes
  localparam logic [1:0] REFSEL_13 = 2'h0;
  localparam logic [1:0] REFSEL_19P2 = 2'h1;
  localparam logic [1:0] REFSEL_26 = 2'h2;
  localparam logic [1:0] REFSEL_24 = 2'h3;

  // Expected reference frequencies in kHz
  localparam logic [15:0] FREQ_13_KHZ = 16'h32C8;
  localparam logic [15:0] FREQ_19P2_KHZ = 16'h4B00;
  localparam logic [15:0] FREQ_26_KHZ = 16'h6590;
  localparam logic [15:0] FREQ_24_KHZ = 16'h5DC0;
  localparam logic [15:0] FREQ_RESET = 16'h0000;

  // Clock start-up waits in microseconds, longest per strap setting
  localparam int T_START_13_US = 3320;
  localparam int T_START_19P2_US = 2650;
  localparam int T_START_26_US = 2280;
  localparam int T_START_24_US = 2500;

  // Start-up waits in system clock cycles
  localparam int START_13_CYC = T_START_13_US * CLOCK_MHZ;
  localparam int START_19P2_CYC = T_START_19P2_US * CLOCK_MHZ;
  localparam int START_26_CYC = T_START_26_US * CLOCK_MHZ;
  localparam int START_24_CYC = T_START_24_US * CLOCK_MHZ;

  // Cycles that the strap synchroniser needs before its output is trusted
  localparam logic [1:0] SETTLE_CYC = 2'h2;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_LAST = 16'h0001;

  // Link-side sequencer, one-hot
  typedef enum logic [5:0] {
    LS_IDLE      = 6'h01,
    LS_LINK_RECV = 6'h02,
    LS_TURN_PHY  = 6'h04,
    LS_PHY_SEND  = 6'h08,
    LS_PHY_DONE  = 6'h10,
    LS_TURN_LINK = 6'h20
  } upi_link_state_t;

  // Start-up sequencer, one-hot
  typedef enum logic [3:0] {
    SS_SETTLE = 4'h1,
    SS_LOAD   = 4'h2,
    SS_WAIT   = 4'h4,
    SS_RUN    = 4'h8
  } upi_start_state_t;

  // One byte with its end-of-packet marker
  typedef struct packed {
    logic last;
    logic [DATA_MSB:DATA_LSB] data;
  } upi_byte_t;

  // Link pins driven by the transceiver, enables active low
  typedef struct packed {
    logic dir;
    logic nxt;
    logic [DATA_MSB:DATA_LSB] data;
    logic data_oe_b;
    logic dir_oe_b;
    logic nxt_oe_b;
  } upi_pins_t;

  localparam upi_pins_t PINS_RESET = '{dir: 1'b0, nxt: 1'b0, data: 8'h00,
                                       data_oe_b: 1'b1, dir_oe_b: 1'b1, nxt_oe_b: 1'b1};
  localparam upi_byte_t BYTE_RESET = '{last: 1'b0, data: 8'h00};

  // Strap code to expected reference frequency
  function automatic logic [15:0] strap_freq(input logic [1:0] straps);
    logic [15:0] f;
    f = FREQ_13_KHZ;
    case (straps)
      REFSEL_13: f = FREQ_13_KHZ;
      REFSEL_19P2: f = FREQ_19P2_KHZ;
      REFSEL_26: f = FREQ_26_KHZ;
      REFSEL_24: f = FREQ_24_KHZ;
      default: f = FREQ_13_KHZ;
    endcase
    return f;
  endfunction

endpackage

// ---- rtl/upi_sync.sv ----
// Two-stage level synchroniser.
// Assumes the input is a level that changes rarely compared with the clock.
`timescale 1ns/1ps
module upi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_level;
      sync_r <= meta_r;
    end
  end

  assign o_level = sync_r;

endmodule

// ---- verification/upi_link_model.sv ----
// Link controller model on the far side of the transceiver link pins.
// Assumes a free-running interface clock; the bench fills tx_q and calls send_packet.
`timescale 1ns/1ps
module upi_link_model (
  input wire logic i_link_clock,
  input upi_pkg::upi_pins_t i_pins,
  output logic [7:0] o_data_in,
  output logic o_stp
);
  import upi_pkg::*;
  logic [7:0] drv_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic dir_q = 1'b0;
  logic dir_w;
  logic link_oe;
  logic [7:0] tx_q[$];
  logic [7:0] got_q[$];
  int n_hang = 0;

  // Link drives only while the transceiver does not own the bus
  assign dir_w = !i_pins.dir_oe_b && i_pins.dir;
  assign link_oe = !dir_w && !dir_q;
  // Released bus shows the inverse of its last value
  assign o_data_in = !i_pins.data_oe_b ? i_pins.data : (link_oe ? drv_r : ~last_r);
  initial o_stp = 1'b0;

  always @(posedge i_link_clock)
  begin
    dir_q <= dir_w;
    last_r <= o_data_in;
    if (dir_w && i_pins.nxt && !i_pins.data_oe_b)
      got_q.push_back(o_data_in);
  end

  // Sends tx_q, waiting slow cycles first, then ends it with a stop pulse
  task automatic send_packet(input int slow);
    int i;
    int guard;
    i = 0;
    guard = 0;
    repeat (slow) @(posedge i_link_clock);
    #1 drv_r = tx_q[0];
    while (i < tx_q.size() && guard < 100)
    begin
      @(posedge i_link_clock);
      guard++;
      if (i_pins.nxt && !dir_w)
      begin
        i++;
        #1 drv_r = (i < tx_q.size()) ? tx_q[i] : 8'h00;
      end
    end
    o_stp = 1'b1;
    @(posedge i_link_clock);
    #1 o_stp = 1'b0;
    if (guard >= 100)
      n_hang++;
  endtask
endmodule

// ---- verification/upi_phy_pins_tb.sv ----
// Self-checking bench for the transceiver link-pin logic.
// Assumes the link model on the data bus and shortened start-up waits.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module upi_phy_pins_tb;
  import upi_pkg::*;
  logic i_clock = 1'b0;
  logic i_link_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [1:0] straps = 2'h0;
  logic [7:0] data_in;
  logic stp;
  upi_byte_t rx_byte = BYTE_RESET;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b1;
  logic clk_out;
  logic clk_oe_b;
  logic rx_ready;
  logic tx_valid;
  logic running;
  upi_pins_t pins;
  upi_byte_t tx_byte;
  logic [15:0] freq;
  upi_byte_t seen_q[$];
  int n_fail = 0;
  int n_tests = 0;

  always #50 i_clock = ~i_clock;
  initial
  begin
    #3.7;
    forever #6 i_link_clock = ~i_link_clock;
  end

  upi_phy_pins #(.START_13_CYCLES(5), .START_19P2_CYCLES(5), .START_26_CYCLES(5), .START_24_CYCLES(5)) dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_link_clock(i_link_clock),
    .i_reference_select_straps(straps), .i_data_in(data_in), .i_stp(stp), .i_rx_byte(rx_byte),
    .i_rx_valid(rx_valid), .i_tx_ready(tx_ready), .o_interface_clock_out(clk_out), .o_clock_oe_b(clk_oe_b),
    .o_pins(pins), .o_rx_ready(rx_ready), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
    .o_ref_freq_khz(freq), .o_running(running));

  upi_link_model link (.i_link_clock(i_link_clock), .i_pins(pins), .o_data_in(data_in), .o_stp(stp));

  always @(posedge i_link_clock)
    if (tx_valid === 1'b1)
      seen_q.push_back(tx_byte);

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    n_fail++;
    $display("[ERR] %s expected done seen timeout", nm);
    stop_test();
  endtask

  // Reset with a strap setting, then start-up and link-side enable
  task automatic t_start(input logic [1:0] s, input logic [15:0] f);
    int g;
    @(posedge i_clock);
    #1 i_rst_b = 1'b0;
    straps = s;
    repeat (3) @(posedge i_clock);
    `CHK("pin enables", 3'h7, {pins.data_oe_b, pins.dir_oe_b, pins.nxt_oe_b})
    `CHK("clock enable", 1'b1, clk_oe_b)
    #1 i_rst_b = 1'b1;
    for (g = 0; g < 40 && running !== 1'b1; g++) @(posedge i_clock);
    if (running !== 1'b1)
      hang("start-up");
    `CHK("ref freq", f, freq)
    `CHK("clock enable", 1'b0, clk_oe_b)
    for (g = 0; g < 40 && pins.dir_oe_b !== 1'b0; g++) @(posedge i_link_clock);
    if (pins.dir_oe_b !== 1'b0)
      hang("link enable");
    `CHK("dir enable", 1'b0, pins.dir_oe_b)
    `CHK("nxt enable", 1'b0, pins.nxt_oe_b)
    `CHK("dir idle", 1'b0, pins.dir)
    @(posedge i_link_clock);
    #1;
    `CHK("clock out high", 1'b1, clk_out)
    @(negedge i_link_clock);
    #1;
    `CHK("clock out low", 1'b0, clk_out)
    $display("done: start-up strap %h", s);
  endtask

  // Link sends a command and two bytes while the core stalls NXT
  task automatic t_link_rx;
    int n;
    int k;
    upi_byte_t ex [3];
    ex[0] = {1'b0, 8'h41};
    ex[1] = {1'b0, 8'hA5};
    ex[2] = {1'b1, 8'h3C};
    n = 0;
    seen_q.delete();
    link.tx_q = '{8'h41, 8'hA5, 8'h3C};
    @(posedge i_link_clock);
    fork
      link.send_packet(0);
      begin
        @(posedge i_link_clock);
        #1 tx_ready = 1'b0;
        @(posedge i_link_clock);
        repeat (3)
        begin
          @(posedge i_link_clock);
          if (pins.nxt !== 1'b0)
            n++;
        end
        #1 tx_ready = 1'b1;
      end
    join
    repeat (3) @(posedge i_link_clock);
    `CHK("stall nxt", 0, n)
    `CHK("link hang", 0, link.n_hang)
    `CHK("rx count", 3, seen_q.size())
    for (k = 0; k < 3; k++)
      `CHK("rx byte", ex[k], seen_q[k])
    `CHK("dir during rx", 1'b0, pins.dir)
    $display("done: link receive");
  endtask

  // Core sends two bytes; turnaround both ways
  task automatic t_phy_tx;
    int g;
    int i;
    upi_byte_t b [2];
    b[0] = {1'b0, 8'h5A};
    b[1] = {1'b1, 8'hC3};
    i = 0;
    link.got_q.delete();
    seen_q.delete();
    @(posedge i_link_clock);
    #1 rx_valid = 1'b1;
    rx_byte = b[0];
    for (g = 0; g < 20 && pins.dir !== 1'b1; g++) @(posedge i_link_clock);
    if (pins.dir !== 1'b1)
      hang("dir up");
    `CHK("dir up", 1'b1, pins.dir)
    `CHK("turnaround up", 1'b1, pins.data_oe_b)
    for (g = 0; g < 20 && i < 2; g++)
    begin
      @(posedge i_link_clock);
      if (rx_ready === 1'b1)
      begin
        i++;
        #1 rx_byte = (i < 2) ? b[i] : BYTE_RESET;
        rx_valid = (i < 2);
      end
    end
    if (i < 2)
      hang("byte take");
    for (g = 0; g < 20 && pins.dir !== 1'b0; g++) @(posedge i_link_clock);
    if (pins.dir !== 1'b0)
      hang("dir down");
    `CHK("turnaround down", 1'b1, pins.data_oe_b)
    repeat (4) @(posedge i_link_clock);
    `CHK("link got count", 2, link.got_q.size())
    `CHK("link got first", 8'h5A, link.got_q[0])
    `CHK("link got last", 8'hC3, link.got_q[1])
    `CHK("no false command", 0, seen_q.size())
    `CHK("nxt idle", 1'b0, pins.nxt)
    `CHK("rx ready idle", 1'b0, rx_ready)
    $display("done: transceiver send");
  endtask

  initial
  begin
    t_start(REFSEL_13, FREQ_13_KHZ);
    t_start(REFSEL_19P2, FREQ_19P2_KHZ);
    t_start(REFSEL_26, FREQ_26_KHZ);
    t_start(REFSEL_24, FREQ_24_KHZ);
    t_link_rx();
    t_phy_tx();
    t_link_rx();
    stop_test();
  end
endmodule
